// [logic/pme_smi_pkg.sv]
// package: register offsets, field positions and reset values for the
// wake-enable / sysmgmt status block.
// assumes byte-wide registers on a plain strobe port, 8-bit offsets.
package pme_smi_pkg;
   localparam logic [7:0] OFF_WAKE_EN4   = 8'h0D;
   localparam logic [7:0] OFF_WAKE_EN5   = 8'h0E;
   localparam logic [7:0] OFF_RSVD       = 8'h0F;
   localparam logic [7:0] OFF_SMI_STATUS_ONE   = 8'h10;
   localparam logic [7:0] OFF_SMI_EN1    = 8'h16;
   localparam logic [7:0] OFF_CTRL       = 8'h20;
   localparam logic [7:0] OFF_IRQ_STS    = 8'h21;
   localparam logic [7:0] OFF_IRQ_MASK   = 8'h22;

   localparam logic [7:0] WAKE_EN_RST    = 8'h00;
   localparam logic [7:0] SMI_STATUS_ONE_RST   = 8'h02;
   localparam logic [7:0] SMI_EN1_RST    = 8'h00;
   localparam logic [7:0] RSVD_VALUE     = 8'h00;
   localparam logic [7:0] ZERO8          = 8'h00;
   // status bits 1..5 carry sources; 0,6,7 reserved
   localparam logic [7:0] SMI_STATUS_ONE_MASK  = 8'h3E;

   localparam int BIT_PAR     = 1;
   localparam int BIT_SER2    = 2;
   localparam int BIT_SER1    = 3;
   localparam int BIT_FLOPPY  = 4;
   localparam int BIT_MIDI    = 5;

   // control register fields
   localparam int CTRL_WAKE_MASTER = 0;
   localparam int CTRL_PAR_ACTIVE  = 1;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CTRL_MASK = 8'h03;

   // interrupt status fields: wake asserted edge, sysmgmt asserted edge
   localparam int IRQ_WAKE = 0;
   localparam int IRQ_SMI  = 1;
   localparam logic [7:0] IRQ_MASK_W = 8'h03;
endpackage : pme_smi_pkg

// [logic/pin_sync.sv]
// three-flop synchroniser; output changes only when stages two and three agree.
// assumes d is asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter logic INIT = 1'b0
) (
   input  wire logic core_clk,
   input  wire logic rstn,
   input  wire logic d,
   output var  logic q
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } sync_s;

   sync_s st_r;
   sync_s st_nxt;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // change only counts once stages two and three agree
      if (st_r.s2 == st_r.s3) begin
         st_nxt.q = st_r.s3;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st_r <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.q;
endmodule : pin_sync
`default_nettype wire

// [logic/wake_gate.sv]
// one 8-bit wake group: enable register gated against status bits.
// assumes status and enable are already in the core_clk domain.
`timescale 1ns/1ps
`default_nettype none
module wake_gate (
   input  wire logic [7:0] status,
   input  wire logic [7:0] enable,
   output var  logic       hit
);
   // disabled sources still show in status, just never reach the output
   assign hit = |(status & enable); // see RQ1 see RQ2
endmodule : wake_gate
`default_nettype wire

// [logic/pme_wake_smi_status.sv]
// wake-enable gating and first sysmgmt status register of a runtime block.
// assumes a byte register port on core_clk (250 MHz), sync active-low rstn
// as standby power-on reset, and main/soft/hard resets all arriving on the one main_reset input.
//
// Overview of operation
// RQ1: an enabled wake source whose status is set drives the wake output when the master wake enable is set.
// RQ2: a disabled wake source still shows in its status but never drives the wake output.
// RQ3: wake enable four bits 0..7 gate gpio_30,31,32,33,41,43,60,61 in that order.
// RQ4: wake enable five bits 0..7 gate gpio_50 through gpio_57 ascending.
// RQ5: wake enables clear to zero only on standby reset and survive main, soft and hard resets.
// RQ6: offset 0F reads zero and writes to it do nothing.
// RQ7: sysmgmt status one shows the live source levels and is not cleared by writes.
// RQ8: status one holds parallel at bit 1, serial two at 2, serial one at 3, floppy at 4, midi at 5.
// RQ9: with the parallel port inactive the parallel flag reads one.
// RQ10: with the parallel port active the parallel flag follows the acknowledge input.
// RQ11: status one resets to 02 on standby reset and bit 1 is forced on main, hard and soft resets.
// RQ12: a status flag reaches the group sysmgmt output only when its enable bit is one.
// RQ13: the active-low wake output is the registered OR of enabled set sources under the master enable.
`timescale 1ns/1ps
`default_nettype none
module pme_wake_smi_status (
   input  wire logic       core_clk,
   input  wire logic       rstn,
   input  wire logic       main_reset,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output var  logic [7:0] rdata,
   input  wire logic [7:0] wake_status_four,
   input  wire logic [7:0] wake_status_five,
   input  wire logic       printer_ack_n,
   input  wire logic       second_serial_irq,
   input  wire logic       first_serial_irq,
   input  wire logic       floppy_irq,
   input  wire logic       midi_irq,
   output var  logic       wake_request_out_n,
   output var  logic       group_sysmgmt_irq_n,
   output var  logic       irq
);
   typedef struct packed {
      logic [7:0] wake_en4;
      logic [7:0] wake_en5;
      logic [7:0] smi_en1;
      logic [7:0] ctrl;
      logic [7:0] smi_status_one;
      logic [7:0] irq_sts;
      logic [7:0] irq_mask;
      logic       force_par;
      logic       wake_act;
      logic       smi_act;
      logic [7:0] rdata;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   logic       ack_s;
   logic       ser2_s;
   logic       ser1_s;
   logic       flop_s;
   logic       midi_s;
   logic [7:0] wk4_s;
   logic [7:0] wk5_s;
   logic       hit4;
   logic       hit5;
   logic [7:0] live_sts;
   logic       par_flag;

   // every asynchronous source passes the three-flop synchroniser with its stage-two/three agreement filter
   pin_sync #(.INIT(1'b1)) u_ack (
      .core_clk (core_clk),
      .rstn     (rstn),
      .d        (printer_ack_n),
      .q        (ack_s)
   );
   pin_sync u_ser2 (
      .core_clk (core_clk),
      .rstn     (rstn),
      .d        (second_serial_irq),
      .q        (ser2_s)
   );
   pin_sync u_ser1 (
      .core_clk (core_clk),
      .rstn     (rstn),
      .d        (first_serial_irq),
      .q        (ser1_s)
   );
   pin_sync u_flop (
      .core_clk (core_clk),
      .rstn     (rstn),
      .d        (floppy_irq),
      .q        (flop_s)
   );
   pin_sync u_midi (
      .core_clk (core_clk),
      .rstn     (rstn),
      .d        (midi_irq),
      .q        (midi_s)
   );

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_wk
         pin_sync u_w4 (
            .core_clk (core_clk),
            .rstn     (rstn),
            .d        (wake_status_four[gi]),
            .q        (wk4_s[gi])
         );
         pin_sync u_w5 (
            .core_clk (core_clk),
            .rstn     (rstn),
            .d        (wake_status_five[gi]),
            .q        (wk5_s[gi])
         );
      end
   endgenerate

   // bit order of the status vectors matches the enable layout
   wake_gate u_gate4 (
      .status (wk4_s),
      .enable (st_r.wake_en4),
      .hit    (hit4)
   ); // see RQ3
   wake_gate u_gate5 (
      .status (wk5_s),
      .enable (st_r.wake_en5),
      .hit    (hit5)
   ); // see RQ4

   // acknowledge is active low; inactive port reads as one
   assign par_flag = st_r.ctrl[pme_smi_pkg::CTRL_PAR_ACTIVE]
                     ? ack_s : 1'b1; // see RQ9 see RQ10

   always_comb begin
      live_sts = pme_smi_pkg::ZERO8;
      live_sts[pme_smi_pkg::BIT_PAR]    = par_flag;
      live_sts[pme_smi_pkg::BIT_SER2]   = ser2_s;
      live_sts[pme_smi_pkg::BIT_SER1]   = ser1_s;
      live_sts[pme_smi_pkg::BIT_FLOPPY] = flop_s;
      live_sts[pme_smi_pkg::BIT_MIDI]   = midi_s; // see RQ8
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = pme_smi_pkg::ZERO8;

      // status tracks the sources; writes never touch it
      st_nxt.smi_status_one = live_sts; // see RQ7
      st_nxt.force_par = 1'b0;
      if (st_r.force_par) begin
         st_nxt.smi_status_one[pme_smi_pkg::BIT_PAR] = 1'b1; // see RQ11
      end
      if (main_reset) begin
         // main resets leave wake enables alone but force the flag
         st_nxt.force_par = 1'b1;
         st_nxt.smi_status_one[pme_smi_pkg::BIT_PAR] = 1'b1; // see RQ11 see RQ5
      end

      st_nxt.wake_act = st_r.ctrl[pme_smi_pkg::CTRL_WAKE_MASTER]
                        & (hit4 | hit5); // see RQ13 see RQ1
      st_nxt.smi_act  = |(st_r.smi_status_one & st_r.smi_en1); // see RQ12

      if (st_nxt.wake_act && !st_r.wake_act) begin
         st_nxt.irq_sts[pme_smi_pkg::IRQ_WAKE] = 1'b1;
      end
      if (st_nxt.smi_act && !st_r.smi_act) begin
         st_nxt.irq_sts[pme_smi_pkg::IRQ_SMI] = 1'b1;
      end

      if (wr) begin
         case (addr)
            pme_smi_pkg::OFF_WAKE_EN4: st_nxt.wake_en4 = wdata;
            pme_smi_pkg::OFF_WAKE_EN5: st_nxt.wake_en5 = wdata;
            pme_smi_pkg::OFF_SMI_EN1:
               st_nxt.smi_en1 = wdata & pme_smi_pkg::SMI_STATUS_ONE_MASK;
            pme_smi_pkg::OFF_CTRL:
               st_nxt.ctrl = wdata & pme_smi_pkg::CTRL_MASK;
            pme_smi_pkg::OFF_IRQ_MASK:
               st_nxt.irq_mask = wdata & pme_smi_pkg::IRQ_MASK_W;
            pme_smi_pkg::OFF_IRQ_STS: begin
               // a new event in the clearing cycle survives the clear
               if (!(st_nxt.wake_act && !st_r.wake_act)
                   && wdata[pme_smi_pkg::IRQ_WAKE]) begin
                  st_nxt.irq_sts[pme_smi_pkg::IRQ_WAKE] = 1'b0;
               end
               if (!(st_nxt.smi_act && !st_r.smi_act)
                   && wdata[pme_smi_pkg::IRQ_SMI]) begin
                  st_nxt.irq_sts[pme_smi_pkg::IRQ_SMI] = 1'b0;
               end
            end
            default: ; // offset 0F and unmapped writes ignored, see RQ6
         endcase
      end

      if (rd) begin
         case (addr)
            pme_smi_pkg::OFF_WAKE_EN4: st_nxt.rdata = st_r.wake_en4;
            pme_smi_pkg::OFF_WAKE_EN5: st_nxt.rdata = st_r.wake_en5;
            pme_smi_pkg::OFF_RSVD:
               st_nxt.rdata = pme_smi_pkg::RSVD_VALUE; // see RQ6
            pme_smi_pkg::OFF_SMI_STATUS_ONE: st_nxt.rdata = st_r.smi_status_one;
            pme_smi_pkg::OFF_SMI_EN1:  st_nxt.rdata = st_r.smi_en1;
            pme_smi_pkg::OFF_CTRL:     st_nxt.rdata = st_r.ctrl;
            pme_smi_pkg::OFF_IRQ_STS:  st_nxt.rdata = st_r.irq_sts;
            pme_smi_pkg::OFF_IRQ_MASK: st_nxt.rdata = st_r.irq_mask;
            default:                   st_nxt.rdata = pme_smi_pkg::ZERO8;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st_r.wake_en4  <= pme_smi_pkg::WAKE_EN_RST; // see RQ5
         st_r.wake_en5  <= pme_smi_pkg::WAKE_EN_RST;
         st_r.smi_en1   <= pme_smi_pkg::SMI_EN1_RST;
         st_r.ctrl      <= pme_smi_pkg::CTRL_RST;
         st_r.smi_status_one  <= pme_smi_pkg::SMI_STATUS_ONE_RST; // see RQ11
         st_r.irq_sts   <= pme_smi_pkg::ZERO8;
         st_r.irq_mask  <= pme_smi_pkg::ZERO8;
         st_r.force_par <= 1'b1;
         st_r.wake_act  <= 1'b0;
         st_r.smi_act   <= 1'b0;
         st_r.rdata     <= pme_smi_pkg::ZERO8;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata               = st_r.rdata;
   assign wake_request_out_n  = ~st_r.wake_act; // see RQ13
   assign group_sysmgmt_irq_n = ~st_r.smi_act;
   assign irq                 = |(st_r.irq_sts & st_r.irq_mask);

   AST_WAKE_MASTER: assert property (@(posedge core_clk) disable iff (!rstn)
      !st_r.ctrl[pme_smi_pkg::CTRL_WAKE_MASTER] |=> wake_request_out_n)
      else $error("wake asserted without master enable"); // see RQ1
   AST_WAKE_DISABLED: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_r.wake_en4 == 8'h00 && st_r.wake_en5 == 8'h00)
      |=> wake_request_out_n)
      else $error("wake asserted with all sources disabled"); // see RQ2
   AST_WAKE_ON: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_r.ctrl[pme_smi_pkg::CTRL_WAKE_MASTER] && hit4)
      |=> !wake_request_out_n)
      else $error("enabled group four did not wake"); // see RQ3
   AST_WAKE_FIVE: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_r.ctrl[pme_smi_pkg::CTRL_WAKE_MASTER]
       && (wk5_s & st_r.wake_en5) != 8'h00)
      |=> !wake_request_out_n)
      else $error("enabled group five did not wake"); // see RQ4
   AST_EN_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
      (main_reset && !wr) |=> $stable(st_r.wake_en4) && $stable(st_r.wake_en5))
      else $error("main reset disturbed wake enables"); // see RQ5
   AST_RSVD_ZERO: assert property (@(posedge core_clk) disable iff (!rstn)
      (rd && addr == pme_smi_pkg::OFF_RSVD) |=> rdata == 8'h00)
      else $error("reserved offset read nonzero"); // see RQ6
   AST_STS_LIVE: assert property (@(posedge core_clk) disable iff (!rstn)
      (!st_r.force_par && !main_reset) |=> st_r.smi_status_one == $past(live_sts))
      else $error("status does not track sources"); // see RQ7
   AST_RSVD_BITS: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_r.smi_status_one & ~pme_smi_pkg::SMI_STATUS_ONE_MASK) == 8'h00)
      else $error("reserved status bit set"); // see RQ8
   AST_PAR_IDLE: assert property (@(posedge core_clk) disable iff (!rstn)
      !st_r.ctrl[pme_smi_pkg::CTRL_PAR_ACTIVE] |=> st_r.smi_status_one[1])
      else $error("parallel flag low while port inactive"); // see RQ9
   AST_PAR_TRACK: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_r.ctrl[pme_smi_pkg::CTRL_PAR_ACTIVE] && !main_reset
       && !st_r.force_par)
      |=> st_r.smi_status_one[1] == $past(ack_s))
      else $error("parallel flag does not follow acknowledge"); // see RQ10
   AST_MAIN_FORCE: assert property (@(posedge core_clk) disable iff (!rstn)
      main_reset |=> st_r.smi_status_one[1] ##1 st_r.smi_status_one[1])
      else $error("main reset did not force parallel flag"); // see RQ11
   AST_SMI_GATE: assert property (@(posedge core_clk) disable iff (!rstn)
      st_r.smi_en1 == 8'h00 |=> group_sysmgmt_irq_n)
      else $error("sysmgmt asserted while all disabled"); // see RQ12
   AST_WAKE_SYNC: assert property (@(posedge core_clk) disable iff (!rstn)
      !wake_request_out_n
      |-> $past(st_r.ctrl[pme_smi_pkg::CTRL_WAKE_MASTER]))
      else $error("wake not qualified one cycle earlier"); // see RQ13
   // off direction of the wake gate and both directions of the sysmgmt gate, one cycle of latency
   AST_WAKE_OFF: assert property (@(posedge core_clk) disable iff (!rstn)
      !(st_r.ctrl[pme_smi_pkg::CTRL_WAKE_MASTER] && (hit4 || hit5))
      |=> wake_request_out_n)
      else $error("wake asserted without an enabled set source"); // see RQ13
   AST_SMI_ON: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_r.smi_status_one & st_r.smi_en1) != pme_smi_pkg::ZERO8
      |=> !group_sysmgmt_irq_n)
      else $error("enabled status flag did not reach sysmgmt"); // see RQ12
   AST_SMI_OFF: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_r.smi_status_one & st_r.smi_en1) == pme_smi_pkg::ZERO8
      |=> group_sysmgmt_irq_n)
      else $error("sysmgmt asserted with no enabled flag"); // see RQ12
   AST_SMI_EN_RSVD: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_r.smi_en1 & ~pme_smi_pkg::SMI_STATUS_ONE_MASK) == pme_smi_pkg::ZERO8)
      else $error("reserved sysmgmt enable bit set"); // see RQ12
   // register port: writes land next cycle, reads answer once then idle
   AST_EN4_WR: assert property (@(posedge core_clk) disable iff (!rstn)
      (wr && addr == pme_smi_pkg::OFF_WAKE_EN4)
      |=> st_r.wake_en4 == $past(wdata))
      else $error("wake enable four write lost"); // see RQ3
   AST_EN5_WR: assert property (@(posedge core_clk) disable iff (!rstn)
      (wr && addr == pme_smi_pkg::OFF_WAKE_EN5)
      |=> st_r.wake_en5 == $past(wdata))
      else $error("wake enable five write lost"); // see RQ4
   AST_RSVD_WR: assert property (@(posedge core_clk) disable iff (!rstn)
      (wr && addr == pme_smi_pkg::OFF_RSVD)
      |=> $stable(st_r.wake_en4) && $stable(st_r.wake_en5))
      else $error("reserved offset write had an effect"); // see RQ6
   AST_STS_RD: assert property (@(posedge core_clk) disable iff (!rstn)
      (rd && addr == pme_smi_pkg::OFF_SMI_STATUS_ONE)
      |=> rdata == $past(st_r.smi_status_one))
      else $error("status read returned stale data"); // see RQ7
   AST_RDATA_IDLE: assert property (@(posedge core_clk) disable iff (!rstn)
      !rd |=> rdata == pme_smi_pkg::ZERO8)
      else $error("read data present without a read");
   // a wake edge in the clearing cycle must still leave the bit set
   AST_WAKE_SET_WINS: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_nxt.wake_act && !st_r.wake_act)
      |=> st_r.irq_sts[pme_smi_pkg::IRQ_WAKE])
      else $error("wake event lost in status");

   COV_WAKE: cover property (@(posedge core_clk) disable iff (!rstn)
      $fell(wake_request_out_n));
   COV_SMI: cover property (@(posedge core_clk) disable iff (!rstn)
      $fell(group_sysmgmt_irq_n));
   COV_IRQ: cover property (@(posedge core_clk) disable iff (!rstn) $rose(irq));
   COV_MAIN: cover property (@(posedge core_clk) disable iff (!rstn)
      main_reset ##1 st_r.ctrl[pme_smi_pkg::CTRL_PAR_ACTIVE]);
   // parallel port active with acknowledge low: the only way bit 1 drops
   COV_PAR_LOW: cover property (@(posedge core_clk) disable iff (!rstn)
      st_r.ctrl[pme_smi_pkg::CTRL_PAR_ACTIVE]
      && !st_r.smi_status_one[pme_smi_pkg::BIT_PAR]);
endmodule : pme_wake_smi_status
`default_nettype wire

// [tb/host_pm_model.sv]
// host-side power management model: samples the active-low wake and
// sysmgmt lines as the chipset would, one register stage.
// assumes both lines are already in the core_clk domain.
`timescale 1ns/1ps
`default_nettype none
module host_pm_model (
   input  wire logic core_clk,
   input  wire logic rstn,
   input  wire logic wake_request_out_n,
   input  wire logic group_sysmgmt_irq_n,
   output var  logic wake_low,
   output var  logic smi_low
);
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         wake_low <= 1'b0;
         smi_low  <= 1'b0;
      end else begin
         wake_low <= !wake_request_out_n;
         smi_low  <= !group_sysmgmt_irq_n;
      end
   end
endmodule : host_pm_model
`default_nettype wire

// [tb/pme_wake_smi_status_tb.sv]
// testbench: register tasks on the strobe port, source pins driven here,
// wake and sysmgmt lines watched through the host model.
// assumes the design settles pin changes within a few cycles.
`timescale 1ns/1ps
`default_nettype none
module pme_wake_smi_status_tb;
   logic        core_clk;
   logic        rstn;
   logic        main_reset;
   logic [7:0]  addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   logic [15:0] ws;
   logic        printer_ack_n;
   logic [3:0]  src;
   logic        wake_n;
   logic        smi_n;
   logic        irq;
   logic        wake_low;
   logic        smi_low;
   int          bad_count;
   int          comparisons;

   pme_wake_smi_status dut (
      .core_clk(core_clk), .rstn(rstn), .main_reset(main_reset),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .wake_status_four(ws[7:0]), .wake_status_five(ws[15:8]),
      .printer_ack_n(printer_ack_n), .second_serial_irq(src[0]),
      .first_serial_irq(src[1]), .floppy_irq(src[2]), .midi_irq(src[3]),
      .wake_request_out_n(wake_n), .group_sysmgmt_irq_n(smi_n), .irq(irq));

   host_pm_model host (
      .core_clk(core_clk), .rstn(rstn), .wake_request_out_n(wake_n),
      .group_sysmgmt_irq_n(smi_n), .wake_low(wake_low), .smi_low(smi_low));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic complete_run();
      $display("mismatches %0d of %0d checks", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      addr <= a; rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1 check(rdata, e);
   endtask : rd_chk

   // bounded wait for the host to see a level; timeout ends the run
   task automatic wait_pin(input bit s, input logic v);
      int n;
      for (n = 0; n < 20; n++) begin
         @(posedge core_clk);
         #1;
         if ((s ? smi_low : wake_low) === v) break;
      end
      check({7'h00, s ? smi_low : wake_low}, {7'h00, v});
      if (n == 20) complete_run();
   endtask : wait_pin

   task automatic settle();
      repeat (10) @(posedge core_clk);
   endtask : settle

   initial begin
      bad_count = 0; comparisons = 0;
      rstn = 1'b0; main_reset = 1'b0; addr = 8'h00; wdata = 8'h00;
      wr = 1'b0; rd = 1'b0; ws = 16'h0000; printer_ack_n = 1'b1;
      src = 4'h0;
      repeat (16) @(posedge core_clk);
      rstn <= 1'b1;
      rd_chk(pme_smi_pkg::OFF_WAKE_EN4, 8'h00);
      rd_chk(pme_smi_pkg::OFF_WAKE_EN5, 8'h00);
      rd_chk(pme_smi_pkg::OFF_SMI_STATUS_ONE, 8'h02);
      wr_reg(pme_smi_pkg::OFF_RSVD, 8'hFF);
      rd_chk(pme_smi_pkg::OFF_RSVD, 8'h00);
      wr_reg(pme_smi_pkg::OFF_SMI_STATUS_ONE, 8'hFF);
      rd_chk(pme_smi_pkg::OFF_SMI_STATUS_ONE, 8'h02);
      rd_chk(8'h30, 8'h00);
      // sources one at a time, each alone onto the group line
      for (int b = 2; b < 6; b++) begin
         src <= 4'h1 << (b - 2);
         wr_reg(pme_smi_pkg::OFF_SMI_EN1, 8'h3C & ~(8'h01 << b));
         settle();
         rd_chk(pme_smi_pkg::OFF_SMI_STATUS_ONE, 8'h02 | (8'h01 << b));
         wait_pin(1'b1, 1'b0);
         wr_reg(pme_smi_pkg::OFF_SMI_EN1, 8'h01 << b);
         wait_pin(1'b1, 1'b1);
      end
      src <= 4'h0;
      settle();
      rd_chk(pme_smi_pkg::OFF_SMI_STATUS_ONE, 8'h02);
      wr_reg(pme_smi_pkg::OFF_CTRL, 8'h02);
      printer_ack_n <= 1'b0;
      settle();
      rd_chk(pme_smi_pkg::OFF_SMI_STATUS_ONE, 8'h00);
      printer_ack_n <= 1'b1;
      settle();
      rd_chk(pme_smi_pkg::OFF_SMI_STATUS_ONE, 8'h02);
      printer_ack_n <= 1'b0;
      wr_reg(pme_smi_pkg::OFF_WAKE_EN4, 8'hA5);
      wr_reg(pme_smi_pkg::OFF_WAKE_EN5, 8'h5A);
      // level main reset: flag forced while held, enables kept
      main_reset <= 1'b1;
      settle();
      rd_chk(pme_smi_pkg::OFF_SMI_STATUS_ONE, 8'h02);
      main_reset <= 1'b0;
      rd_chk(pme_smi_pkg::OFF_WAKE_EN4, 8'hA5);
      rd_chk(pme_smi_pkg::OFF_WAKE_EN5, 8'h5A);
      settle();
      rd_chk(pme_smi_pkg::OFF_SMI_STATUS_ONE, 8'h00);
      wr_reg(pme_smi_pkg::OFF_CTRL, 8'h00);
      settle();
      rd_chk(pme_smi_pkg::OFF_SMI_STATUS_ONE, 8'h02);
      // master off: a set enabled source must not wake
      ws <= 16'h0001;
      settle();
      check({7'h00, wake_low}, 8'h00);
      wr_reg(pme_smi_pkg::OFF_CTRL, 8'h01);
      for (int i = 0; i < 16; i++) begin
         ws <= 16'h0001 << i;
         wr_reg(pme_smi_pkg::OFF_WAKE_EN4, 8'h01 << i);
         wr_reg(pme_smi_pkg::OFF_WAKE_EN5, 8'h01 << (i - 8));
         wait_pin(1'b0, 1'b1);
         wr_reg(pme_smi_pkg::OFF_WAKE_EN4, ~(8'h01 << i));
         wr_reg(pme_smi_pkg::OFF_WAKE_EN5, ~(8'h01 << (i - 8)));
         wait_pin(1'b0, 1'b0);
      end
      // sticky events, mask and write-one-to-clear
      rd_chk(pme_smi_pkg::OFF_IRQ_STS, 8'h03);
      wr_reg(pme_smi_pkg::OFF_IRQ_MASK, 8'h01);
      @(posedge core_clk);
      #1 check({7'h00, irq}, 8'h01);
      wr_reg(pme_smi_pkg::OFF_IRQ_MASK, 8'h00);
      @(posedge core_clk);
      #1 check({7'h00, irq}, 8'h00);
      wr_reg(pme_smi_pkg::OFF_IRQ_STS, 8'h03);
      rd_chk(pme_smi_pkg::OFF_IRQ_STS, 8'h00);
      wr_reg(pme_smi_pkg::OFF_IRQ_MASK, 8'h03);
      @(posedge core_clk);
      #1 check({7'h00, irq}, 8'h00);
      complete_run();
   end
endmodule : pme_wake_smi_status_tb
`default_nettype wire
